// ===== core/mssi_regs.svh
// Register offsets, field positions and reset values of the init sequencer
`ifndef MSSI_REGS_SVH
`define MSSI_REGS_SVH

// ----------------------------------------------------------------
// Own APB register map (byte addresses)
// ----------------------------------------------------------------
`define MSSI_A_CTRL      12'h000
`define MSSI_A_STATUS    12'h004
`define MSSI_A_MODE      12'h008
`define MSSI_A_SESS_EN   12'h00C
`define MSSI_A_TGT_MAP   12'h010
`define MSSI_A_SMAC_LO   12'h014
`define MSSI_A_SMAC_HI   12'h018
`define MSSI_A_LOCAL_IP  12'h01C
`define MSSI_A_TIP_BASE  8'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSSI_CTRL_START  0
`define MSSI_LINK_BIT    16
`define MSSI_BUSY_BIT    0
`define MSSI_RST_BIT     0
`define MSSI_MCAST_BIT   8

// ----------------------------------------------------------------
// Engine side address map (per engine window)
// ----------------------------------------------------------------
`define MSSI_ENG_SHIFT   13
`define MSSI_E_SML       16'h0000
`define MSSI_E_SMH       16'h0004
`define MSSI_E_DIP       16'h0008
`define MSSI_E_LIP       16'h000C
`define MSSI_E_DML       16'h0010
`define MSSI_E_DMH       16'h0014
`define MSSI_E_MODE      16'h0018
`define MSSI_E_RST       16'h001C
`define MSSI_E_CMD       16'h0020
`define MSSI_U_RST       16'h1000

// ----------------------------------------------------------------
// Init mode codes and reset values
// ----------------------------------------------------------------
`define MSSI_M_CLIENT    2'h0
`define MSSI_M_SERVER    2'h1
`define MSSI_M_FIXED     2'h2
`define MSSI_M_BAD       2'h3
`define MSSI_RST_MODE    2'h0
`define MSSI_RST_EN      4'hF
`define MSSI_RST_MAP     8'h00
`define MSSI_RST_SMAC_LO 32'h0000_0000
`define MSSI_RST_SMAC_HI 16'h0000
`define MSSI_RST_IP      32'h0000_0000
`define MSSI_END_IDX     3'h4

`endif

// ===== core/mssi_pkg.sv
// Types shared by the init sequencer
package mssi_pkg;

    typedef enum logic [3:0] {
        S_LINK, S_HOLD, S_ULRST, S_SMAC_L, S_SMAC_H, S_LIP, S_DIP,
        S_MODE, S_DML_W, S_DMH_W, S_REL, S_POLL, S_DML_R, S_DMH_R,
        S_DONE
    } mssi_state_t;

endpackage

// ===== core/mssi_sequencer.sv
// Multi-session offload engine init sequencer with APB control
// Summary of operation
// - Poll link-up bit 16 before initializing
// - Four sessions, one IP, any subset used
// - At most four sessions across all targets
// - First session per target takes mode, others fixed
// - Done only when every active busy clears
// - Hold all engines reset before reloading
// - Per session: reset pattern logic, load parameters
// - First session: release, wait, read target MAC
// - Others: fixed mode, copy MAC, release, wait
// - Invalid common parameter keeps old value
`timescale 1ns/10ps
`default_nettype none
`include "mssi_regs.svh"

module mssi_sequencer
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output var  logic        mst_req,
    output var  logic        mst_wr,
    output var  logic [15:0] mst_addr,
    output var  logic [31:0] mst_wdata,
    input  wire logic        mst_ack,
    input  wire logic [31:0] mst_rdata,
    output logic             init_done
);
    import mssi_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // A session is first of its target when no lower enabled one shares it
    function automatic logic is_first(input logic [3:0] en,
                                      input logic [7:0] map,
                                      input logic [2:0] i);
        logic f;
        f = 1'b1;
        for (int j = 0; j < 4; j++)
            if (j < int'(i) && en[j] && map[2*j +: 2] == map[2*i[1:0] +: 2])
                f = 1'b0;
        return f;
    endfunction

    // Lowest enabled index at or above 'from', end marker if none
    function automatic logic [2:0] next_en(input logic [3:0] en,
                                           input logic [2:0] from);
        logic [2:0] r;
        r = `MSSI_END_IDX;
        for (int j = 3; j >= 0; j--)
            if (en[j] && j >= int'(from))
                r = 3'(j);
        return r;
    endfunction

    // Byte address of an engine-side register
    function automatic logic [15:0] eng_addr(input logic [2:0] i,
                                             input logic [15:0] off);
        return 16'(i[1:0]) << `MSSI_ENG_SHIFT | off;
    endfunction

    // Own register decode, shared by write accept and error answer
    function automatic logic reg_hit(input logic [11:0] a);
        return a <= `MSSI_A_LOCAL_IP || a[11:4] == `MSSI_A_TIP_BASE;
    endfunction

    // ------------------------------------------------------------
    // APB register file
    // ------------------------------------------------------------
    logic [1:0]  mode;
    logic [3:0]  sess_en;
    logic [7:0]  tgt_map;
    logic [31:0] smac_lo;
    logic [15:0] smac_hi;
    logic [31:0] local_ip;
    logic [31:0] tgt_ip [4];
    logic        start;
    logic        rejected;
    logic [1:0]  next_mode;
    logic [3:0]  next_sess_en;
    logic [7:0]  next_tgt_map;
    logic [31:0] next_smac_lo;
    logic [15:0] next_smac_hi;
    logic [31:0] next_local_ip;
    logic [31:0] next_tgt_ip [4];
    logic        next_start;
    logic        next_rejected;
    logic [31:0] next_prdata;
    logic        wr_acc;
    mssi_state_t state;
    logic [2:0]  idx;

    // Zero-wait slave; read data is latched in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~reg_hit(paddr);
    assign wr_acc  = psel & penable & pwrite & reg_hit(paddr);

    // Writes, validation of common parameters and read mux
    always_comb
    begin
        next_mode     = mode;
        next_sess_en  = sess_en;
        next_tgt_map  = tgt_map;
        next_smac_lo  = smac_lo;
        next_smac_hi  = smac_hi;
        next_local_ip = local_ip;
        next_tgt_ip   = tgt_ip;
        next_start    = 1'b0;
        next_rejected = rejected;
        next_prdata   = prdata;
        if (wr_acc)
        begin
            unique case (paddr)
                `MSSI_A_CTRL:     next_start = pwdata[`MSSI_CTRL_START];
                `MSSI_A_MODE:
                begin
                    next_rejected = pwdata[1:0] == `MSSI_M_BAD;
                    if (!next_rejected)
                        next_mode = pwdata[1:0];
                end
                `MSSI_A_SESS_EN:  next_sess_en = pwdata[3:0];
                `MSSI_A_TGT_MAP:  next_tgt_map = pwdata[7:0];
                `MSSI_A_SMAC_LO:  next_smac_lo = pwdata;
                `MSSI_A_SMAC_HI:
                begin
                    // Group MAC cannot be a source address
                    next_rejected = pwdata[`MSSI_MCAST_BIT];
                    if (!next_rejected)
                        next_smac_hi = pwdata[15:0];
                end
                `MSSI_A_LOCAL_IP:
                begin
                    next_rejected = pwdata == 32'h0000_0000
                                  || pwdata == 32'hFFFF_FFFF;
                    if (!next_rejected)
                        next_local_ip = pwdata;
                end
                default:
                    if (paddr[11:4] == `MSSI_A_TIP_BASE)
                        next_tgt_ip[paddr[3:2]] = pwdata;
            endcase
        end
        if (psel && !penable && !pwrite)
        begin
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                `MSSI_A_STATUS:   next_prdata = {13'h0000, idx,
                                      12'h000, rejected,
                                      state != S_LINK && state != S_DONE,
                                      state != S_LINK, init_done};
                `MSSI_A_MODE:     next_prdata[1:0] = mode;
                `MSSI_A_SESS_EN:  next_prdata[3:0] = sess_en;
                `MSSI_A_TGT_MAP:  next_prdata[7:0] = tgt_map;
                `MSSI_A_SMAC_LO:  next_prdata = smac_lo;
                `MSSI_A_SMAC_HI:  next_prdata[15:0] = smac_hi;
                `MSSI_A_LOCAL_IP: next_prdata = local_ip;
                default:
                    if (paddr[11:4] == `MSSI_A_TIP_BASE)
                        next_prdata = tgt_ip[paddr[3:2]];
            endcase
        end
    end

    // Register stage of the APB file
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode     <= `MSSI_RST_MODE;
            sess_en  <= `MSSI_RST_EN;
            tgt_map  <= `MSSI_RST_MAP;
            smac_lo  <= `MSSI_RST_SMAC_LO;
            smac_hi  <= `MSSI_RST_SMAC_HI;
            local_ip <= `MSSI_RST_IP;
            tgt_ip   <= '{default: 32'h0000_0000};
            start    <= 1'b0;
            rejected <= 1'b0;
            prdata   <= 32'h0000_0000;
        end
        else
        begin
            mode     <= next_mode;
            sess_en  <= next_sess_en;
            tgt_map  <= next_tgt_map;
            smac_lo  <= next_smac_lo;
            smac_hi  <= next_smac_hi;
            local_ip <= next_local_ip;
            tgt_ip   <= next_tgt_ip;
            start    <= next_start;
            rejected <= next_rejected;
            prdata   <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic [47:0] tgt_mac [4];
    mssi_state_t next_state;
    logic [2:0]  next_idx;
    logic [47:0] next_tgt_mac [4];
    logic        next_mst_req;
    logic        next_mst_wr;
    logic [15:0] next_mst_addr;
    logic [31:0] next_mst_wdata;
    logic        first;
    logic [1:0]  tgt;
    logic [2:0]  nxt;

    assign init_done = state == S_DONE;
    assign first     = is_first(sess_en, tgt_map, idx);
    assign tgt       = tgt_map[2*idx[1:0] +: 2];

    // One engine access per state; request is issued, then held to ack
    always_comb
    begin
        next_state     = state;
        next_idx       = idx;
        next_tgt_mac   = tgt_mac;
        next_mst_req   = mst_req;
        next_mst_wr    = mst_wr;
        next_mst_addr  = mst_addr;
        next_mst_wdata = mst_wdata;
        nxt            = next_en(sess_en, 3'(idx + 3'h1));
        if (state == S_DONE)
        begin
            if (start)
                next_state = S_LINK;
        end
        else if (!mst_req)
        begin
            next_mst_req   = 1'b1;
            next_mst_wr    = 1'b1;
            next_mst_wdata = 32'h0000_0000;
            unique case (state)
                S_LINK:
                begin
                    next_mst_wr   = 1'b0;
                    next_mst_addr = eng_addr(3'h0, `MSSI_U_RST);
                end
                S_HOLD:
                begin
                    next_mst_addr = eng_addr(idx, `MSSI_E_RST);
                    next_mst_wdata[`MSSI_RST_BIT] = 1'b1;
                end
                S_ULRST:
                begin
                    next_mst_addr = eng_addr(idx, `MSSI_U_RST);
                    next_mst_wdata[`MSSI_RST_BIT] = 1'b1;
                end
                S_SMAC_L:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_SML);
                    next_mst_wdata = smac_lo;
                end
                S_SMAC_H:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_SMH);
                    next_mst_wdata = {16'h0000, smac_hi};
                end
                S_LIP:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_LIP);
                    next_mst_wdata = local_ip;
                end
                S_DIP:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_DIP);
                    next_mst_wdata = tgt_ip[idx[1:0]];
                end
                S_MODE:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_MODE);
                    next_mst_wdata[1:0] = first ? mode
                                        : `MSSI_M_FIXED;
                end
                S_DML_W:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_DML);
                    next_mst_wdata = tgt_mac[tgt][31:0];
                end
                S_DMH_W:
                begin
                    next_mst_addr  = eng_addr(idx, `MSSI_E_DMH);
                    next_mst_wdata = {16'h0000, tgt_mac[tgt][47:32]};
                end
                S_REL:   next_mst_addr = eng_addr(idx, `MSSI_E_RST);
                S_POLL:
                begin
                    next_mst_wr   = 1'b0;
                    next_mst_addr = eng_addr(idx, `MSSI_E_CMD);
                end
                S_DML_R:
                begin
                    next_mst_wr   = 1'b0;
                    next_mst_addr = eng_addr(idx, `MSSI_E_DML);
                end
                S_DMH_R:
                begin
                    next_mst_wr   = 1'b0;
                    next_mst_addr = eng_addr(idx, `MSSI_E_DMH);
                end
                default: next_mst_req = 1'b0;
            endcase
        end
        else if (mst_ack)
        begin
            next_mst_req = 1'b0;
            unique case (state)
                S_LINK:
                    if (mst_rdata[`MSSI_LINK_BIT])
                    begin
                        next_state = S_HOLD;
                        next_idx   = 3'h0;
                    end
                S_HOLD:
                    // Every engine is held, used or not
                    if (idx == 3'h3)
                    begin
                        next_idx   = next_en(sess_en, 3'h0);
                        next_state = next_idx == `MSSI_END_IDX
                                   ? S_DONE : S_ULRST;
                    end
                    else
                        next_idx = 3'(idx + 3'h1);
                S_ULRST:  next_state = S_SMAC_L;
                S_SMAC_L: next_state = S_SMAC_H;
                S_SMAC_H: next_state = S_LIP;
                S_LIP:    next_state = S_DIP;
                S_DIP:    next_state = S_MODE;
                S_MODE:
                    if (nxt == `MSSI_END_IDX)
                    begin
                        // Lowest enabled session is always first of target
                        next_idx   = next_en(sess_en, 3'h0);
                        next_state = S_REL;
                    end
                    else
                    begin
                        next_idx   = nxt;
                        next_state = S_ULRST;
                    end
                S_DML_W:  next_state = S_DMH_W;
                S_DMH_W:  next_state = S_REL;
                S_REL:    next_state = S_POLL;
                S_POLL:
                    if (!mst_rdata[`MSSI_BUSY_BIT])
                    begin
                        if (first)
                            next_state = S_DML_R;
                        else if (nxt == `MSSI_END_IDX)
                            next_state = S_DONE;
                        else
                        begin
                            next_idx   = nxt;
                            next_state = is_first(sess_en, tgt_map, nxt)
                                       ? S_REL : S_DML_W;
                        end
                    end
                S_DML_R:
                begin
                    next_tgt_mac[tgt][31:0] = mst_rdata;
                    next_state = S_DMH_R;
                end
                S_DMH_R:
                begin
                    next_tgt_mac[tgt][47:32] = mst_rdata[15:0];
                    if (nxt == `MSSI_END_IDX)
                        next_state = S_DONE;
                    else
                    begin
                        next_idx   = nxt;
                        next_state = is_first(sess_en, tgt_map, nxt)
                                   ? S_REL : S_DML_W;
                    end
                end
                default: next_state = state;
            endcase
        end
    end

    // Register stage of the sequencer; boot starts with link polling
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= S_LINK;
            idx       <= 3'h0;
            tgt_mac   <= '{default: 48'h0000_0000_0000};
            mst_req   <= 1'b0;
            mst_wr    <= 1'b0;
            mst_addr  <= 16'h0000;
            mst_wdata <= 32'h0000_0000;
        end
        else
        begin
            state     <= next_state;
            idx       <= next_idx;
            tgt_mac   <= next_tgt_mac;
            mst_req   <= next_mst_req;
            mst_wr    <= next_mst_wr;
            mst_addr  <= next_mst_addr;
            mst_wdata <= next_mst_wdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence acked_in(mssi_state_t s);
        state == s && mst_req && mst_ack;
    endsequence

    link_gate_a: assert property (acked_in(S_LINK) ##0 !mst_rdata[16]
        |=> state == S_LINK) else $error("left link poll early");
    hold_write_a: assert property (state == S_HOLD && mst_req
        |-> mst_wr && mst_wdata[0] && mst_addr[4:0] == 5'h1C)
        else $error("hold reset not written as one");
    pattern_rst_a: assert property (acked_in(S_ULRST)
        |=> state == S_SMAC_L ##1 mst_req && mst_addr[12:0] == 13'h0000)
        else $error("pattern reset not followed by load");
    fixed_mode_a: assert property (state == S_MODE && mst_req && !first
        |-> mst_wdata[1:0] == 2'h2) else $error("mode not fixed");
    busy_hold_a: assert property (acked_in(S_POLL) ##0 mst_rdata[0]
        |=> state == S_POLL ##1 mst_req && !mst_wr)
        else $error("busy ignored");
    first_read_a: assert property (acked_in(S_POLL) ##0 !mst_rdata[0]
        && first |=> state == S_DML_R) else $error("MAC not read");
    mac_copy_a: assert property (state == S_DML_W && mst_req
        |-> mst_wr && mst_addr[4:0] == 5'h10
        && mst_wdata == tgt_mac[tgt][31:0])
        else $error("copied MAC differs");
    mode_keep_a: assert property (wr_acc && paddr == 12'h008
        && pwdata[1:0] == 2'h3 |=> mode == $past(mode) && rejected)
        else $error("bad mode accepted");
    order_a: assert property (state == S_REL && $past(state) != S_REL
        && $past(state) != S_MODE |-> idx > $past(idx)
        || $past(state) == S_DMH_W) else $error("session order");
    unused_a: assert property (mst_req && state != S_HOLD
        && state != S_LINK |-> sess_en[mst_addr[14:13]])
        else $error("unused engine touched");

endmodule

`default_nettype wire

// ===== sim/mssi_engine_model.sv
// Behavioural fabric of four offload engines and their user logic
`timescale 1ns/10ps
`default_nettype none
`include "mssi_regs.svh"
module mssi_engine_model
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        mst_req,
    input  wire logic        mst_wr,
    input  wire logic [15:0] mst_addr,
    input  wire logic [31:0] mst_wdata,
    input  wire logic        link_up,
    input  wire logic        slow,
    output logic             mst_ack,
    output logic [31:0]      mst_rdata
);
    logic [31:0] mem [logic [15:0]];
    int          busy [4] = '{0, 0, 0, 0};
    int          wait_n;
    int          n_wr = 0;
    int          n_rd = 0;
    int          rel_q [$];
    bit          order_bad = 1'b0;

    // Apply one taken request; a release starts three busy polls
    task automatic serve();
        logic [2:0]  e;
        logic [15:0] b;
        logic [15:0] o;
        e = mst_addr[15:13];
        b = 16'(e) << `MSSI_ENG_SHIFT;
        o = mst_addr - b;
        if (mst_wr)
        begin
            n_wr++;
            mem[mst_addr] = mst_wdata;
            for (int i = 0; i < 4; i++)
                if (o == `MSSI_U_RST && mst_wdata[0] &&
                    mem[16'(i << `MSSI_ENG_SHIFT) + `MSSI_E_RST] !== 32'h1)
                    order_bad = 1'b1;
            if (o == `MSSI_E_RST && !mst_wdata[0])
            begin
                if (busy.sum() != 0)
                    order_bad = 1'b1;
                rel_q.push_back(int'(e));
                busy[e] = 3;
                // Target answers address resolution unless MAC is fixed
                if (mem[b + `MSSI_E_MODE] !== 32'(`MSSI_M_FIXED))
                begin
                    mem[b + `MSSI_E_DML] = 32'hA0B0_C000 + e;
                    mem[b + `MSSI_E_DMH] = 32'h0000_D000 + e;
                end
            end
        end
        else
        begin
            n_rd++;
            if (o == `MSSI_E_CMD)
            begin
                mst_rdata <= {31'h0, busy[e] != 0};
                if (busy[e] != 0)
                    busy[e]--;
            end
            else if (mst_addr == `MSSI_U_RST)
                mst_rdata <= {15'h0, link_up, 16'h0};
            else
                mst_rdata <= mem.exists(mst_addr) ? mem[mst_addr] : 32'h0;
        end
    endtask

    // Ack after 0 or 3 cycles; idle read data toggles so stale use shows
    // Plain always: the bench clears the release log between runs
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mst_ack   <= 1'b0;
            mst_rdata <= 32'h5A5A_5A5A;
            wait_n    <= 0;
        end
        else if (mst_req && !mst_ack && wait_n >= (slow ? 3 : 0))
        begin
            wait_n  <= 0;
            mst_ack <= 1'b1;
            serve();
        end
        else
        begin
            mst_ack   <= 1'b0;
            mst_rdata <= ~mst_rdata;
            if (mst_req && !mst_ack)
                wait_n <= wait_n + 1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/tb_multi_session_init_sequencer.sv
// Self-checking bench for the multi-session init sequencer
`timescale 1ns/10ps
`default_nettype none
`include "mssi_regs.svh"
module tb_multi_session_init_sequencer;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;
                    logic e;} mssi_row_t;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0;
    logic        link_up = 1'b0;
    logic        slow    = 1'b0;
    logic [31:0] prdata, mst_wdata, mst_rdata, rd;
    logic [15:0] mst_addr;
    logic        pready, pslverr, mst_req, mst_wr, mst_ack, init_done, err;
    int          n_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    // Sessions 0,1 on target 0, session 3 on target 1, session 2 unused
    mssi_row_t   rows [14] = '{
        '{12'h008, 32'h1, 32'h1, 0}, '{12'h008, 32'h3, 32'h1, 0},
        '{12'h014, 32'h0203_0405, 32'h0203_0405, 0},
        '{12'h018, 32'h0100, 32'h0, 0}, '{12'h018, 32'h0001, 32'h1, 0},
        '{12'h01C, 32'hC0A8_192A, 32'hC0A8_192A, 0},
        '{12'h01C, 32'hFFFF_FFFF, 32'hC0A8_192A, 0},
        '{12'h01C, 32'h0, 32'hC0A8_192A, 0}, '{12'h004, 32'h0, 32'h8, 0},
        '{12'h0FC, 32'h7, 32'h0, 1},
        '{12'h00C, 32'hB, 32'hB, 0}, '{12'h010, 32'h40, 32'h40, 0},
        '{12'h02C, 32'hC0A8_1903, 32'hC0A8_1903, 0},
        '{12'h008, 32'h0, 32'h0, 0}};

    always #25 sys_clk = ~sys_clk;

    mssi_sequencer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mst_req(mst_req), .mst_wr(mst_wr), .mst_addr(mst_addr),
        .mst_wdata(mst_wdata), .mst_ack(mst_ack), .mst_rdata(mst_rdata),
        .init_done(init_done));
    mssi_engine_model engines (.sys_clk(sys_clk), .rst_n(rst_n),
        .mst_req(mst_req), .mst_wr(mst_wr), .mst_addr(mst_addr),
        .mst_wdata(mst_wdata), .link_up(link_up), .slow(slow),
        .mst_ack(mst_ack), .mst_rdata(mst_rdata));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] er(input int e, input logic [15:0] o);
        return engines.mem[16'(e << `MSSI_ENG_SHIFT) + o];
    endfunction

    // Bounded wait for completion, then the engine-side results
    task automatic check_run(input logic [1:0] m);
        for (int n = 0; n < 5000 && init_done !== 1'b1; n++)
            @(posedge sys_clk);
        check(init_done === 1'b1 && engines.busy.sum() == 0, "done");
        check(er(0, `MSSI_E_MODE) === 32'(m), "mode s0");
        check(er(3, `MSSI_E_MODE) === 32'(m), "mode s3");
        check(er(1, `MSSI_E_MODE) === 32'h2, "mode s1");
        check(er(1, `MSSI_E_DML) === er(0, `MSSI_E_DML), "dml");
        check(er(1, `MSSI_E_DMH) === er(0, `MSSI_E_DMH), "dmh");
        check(er(2, `MSSI_E_RST) === 32'h1, "unused s2");
        check(er(3, `MSSI_E_DIP) === 32'hC0A8_1903, "dip");
        check(er(1, `MSSI_E_LIP) === 32'hC0A8_192A, "lip");
        check(er(0, `MSSI_E_SML) === 32'h0203_0405, "sml");
        check(engines.rel_q.size() == 3 && engines.rel_q[0] == 0 &&
              engines.rel_q[1] == 1 && engines.rel_q[2] == 3, "order");
        check(!engines.order_bad, "hold");
        apb(0, `MSSI_A_STATUS, 0);
        check(rd === 32'h0003_0003, "status");
        $display("run mode %0d done", m);
    endtask

    // Cut a hang short
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        check(init_done === 1'b0 && mst_req === 1'b0, "reset outs");
        rst_n <= 1'b1;
        apb(0, `MSSI_A_SESS_EN, 0);
        check(rd === 32'hF, "sess_en reset");
        apb(0, `MSSI_A_MODE, 0);
        check(rd === 32'h0, "mode reset");
        foreach (rows[i])
        begin
            apb(1, rows[i].a, rows[i].w);
            apb(0, rows[i].a, 0);
            check(rd === rows[i].r && err === rows[i].e, "reg row");
        end
        check(engines.n_wr == 0 && engines.n_rd > 2, "link wait");
        $display("register rows done");
        link_up <= 1'b1;
        check_run(2'h0);
        slow <= 1'b1;
        for (int m = 1; m < 4; m++)
        begin
            engines.rel_q.delete();
            apb(1, `MSSI_A_MODE, 32'(m % 3));
            apb(1, `MSSI_A_CTRL, 32'h1);
            // Start lands on the last edge of the write, the state change one edge after
            repeat (2) @(posedge sys_clk);
            check(init_done === 1'b0, "restart");
            check_run(2'(m % 3));
        end
        end_of_test();
    end
endmodule
`default_nettype wire
